/* File: ceb_bus_cycles.sv */
// External bus master: T-state sequencer, strobes, refresh and bus hand-over.
`default_nettype none

module ceb_bus_cycles (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire ceb_pkg::ceb_kind_type req_kind_in,
    input wire logic [ceb_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [ceb_pkg::DATA_W-1:0] req_wdata_in,
    input wire logic [ceb_pkg::DATA_W-1:0] refresh_high_in,
    input wire logic refresh_addr_bit7_ctl_in,
    output logic done_out,
    output logic [ceb_pkg::DATA_W-1:0] rdata_out,
    input wire logic wait_n_in,
    input wire logic bus_request_n_in,
    output logic bus_grant_n_out,
    input wire logic evaluator_float_in,
    output logic [ceb_pkg::ADDR_W-1:0] address_lines_out,
    output logic address_lines_oe_out,
    input wire logic [ceb_pkg::DATA_W-1:0] data_lines_in,
    output logic [ceb_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_out,
    output logic first_cycle_strobe_n_out,
    output logic first_cycle_strobe_oe_out,
    output logic memory_request_n_out,
    output logic io_request_n_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out,
    output logic control_oe_out,
    output logic refresh_strobe_n_out,
    output logic refresh_strobe_oe_out,
    input wire logic counter_timer_irq_in,
    input wire logic serial_irq_in,
    input wire logic priority_sel_in,
    output logic int_pending_out,
    output logic [ceb_pkg::NUM_IRQ_UNITS-1:0] int_source_out
);
    import ceb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ceb_state_type state;
    ceb_state_type next_state;
    ceb_kind_type kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [REFRESH_W-1:0] refresh_count;
    logic [1:0] auto_waits;
    logic [NUM_IRQ_UNITS-1:0] served_source;
    logic grant_n;
    logic wait_n_sync;
    logic bus_request_n_sync;
    logic evaluator_float_sync;
    logic [NUM_IRQ_UNITS-1:0] unit_irq;
    logic [NUM_IRQ_UNITS-1:0] unit_grant;
    logic unit_any;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; wait idles high, bus request idles high
    ceb_sync #(
        .WIDTH(2),
        .RESET_LEVEL(1'b1)
    ) u_sync_high (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in({wait_n_in, bus_request_n_in}),
        .sync_out({wait_n_sync, bus_request_n_sync})
    );

    // Float request idles low
    ceb_sync #(
        .WIDTH(1),
        .RESET_LEVEL(1'b0)
    ) u_sync_float (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in(evaluator_float_in),
        .sync_out(evaluator_float_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Built-in interrupt source priority
    assign unit_irq[TIMER_UNIT_IDX] = counter_timer_irq_in;
    assign unit_irq[SERIAL_UNIT_IDX] = serial_irq_in;

    ceb_int_priority #(
        .NUM(NUM_IRQ_UNITS)
    ) u_priority (
        .irq_in(unit_irq),
        .reverse_order_in(priority_sel_in),
        .grant_out(unit_grant),
        .any_out(unit_any)
    );

    assign int_pending_out = unit_any;
    assign int_source_out = served_source;

    ////////////////////////////////////////////////////////////////////////
    // State and kind decode
    wire in_idle = (state == ST_IDLE);
    wire in_t1 = (state == ST_T1);
    wire in_t2 = (state == ST_T2);
    wire in_tw = (state == ST_TW);
    wire in_t3 = (state == ST_T3);
    wire in_t4 = (state == ST_T4);
    wire in_hold = (state == ST_HOLD);
    wire is_fetch = (kind == KIND_FETCH);
    wire is_int_ack = (kind == KIND_INT_ACK);
    wire is_mem = is_fetch | (kind == KIND_MEM_RD) | (kind == KIND_MEM_WR);
    wire is_io = (kind == KIND_IO_RD) | (kind == KIND_IO_WR);
    wire is_read = is_fetch | (kind == KIND_MEM_RD) | (kind == KIND_IO_RD);
    wire is_write = (kind == KIND_MEM_WR) | (kind == KIND_IO_WR);
    wire in_access = in_t1 | in_t2 | in_tw;
    wire in_refresh = is_fetch & (in_t3 | in_t4);
    wire auto_wait_left = is_int_ack & (auto_waits != INTA_AUTO_WAITS);

    // Strobe phase ends when wait is released and auto waits are spent
    wire access_last = (in_t2 | in_tw) & wait_n_sync & ~auto_wait_left;

    // Machine cycle end: T4 after a fetch, T3 otherwise
    wire cycle_end = in_t4 | (in_t3 & ~is_fetch);
    wire bus_wanted = ~bus_request_n_sync;
    wire can_start = (in_idle | cycle_end) & ~bus_wanted;
    wire take = req_valid_in & can_start;

    assign req_ready_out = can_start;
    assign done_out = cycle_end;
    assign rdata_out = rdata;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (bus_wanted) begin
                    next_state = ST_HOLD;
                end else if (req_valid_in) begin
                    next_state = ST_T1;
                end
            end
            ST_T1: begin
                next_state = ST_T2;
            end
            ST_T2, ST_TW: begin
                if (access_last) begin
                    next_state = ST_T3;
                end else begin
                    next_state = ST_TW;
                end
            end
            ST_T3: begin
                if (is_fetch) begin
                    next_state = ST_T4;
                end else if (bus_wanted) begin
                    next_state = ST_HOLD;
                end else if (req_valid_in) begin
                    next_state = ST_T1;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_T4: begin
                if (bus_wanted) begin
                    next_state = ST_HOLD;
                end else if (req_valid_in) begin
                    next_state = ST_T1;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                // Leave only once grant is back high, so no overlap of drivers
                if (~bus_wanted & grant_n) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer register
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request latch; a second opcode byte is just another fetch request
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            kind <= KIND_FETCH;
            addr <= ADDR_RESET;
            wdata <= DATA_RESET;
        end else if (take) begin
            kind <= req_kind_in;
            addr <= req_addr_in;
            wdata <= req_wdata_in;
        end
    end

    // Auto wait counter for interrupt acknowledge
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            auto_waits <= 2'h0;
        end else if (in_t1) begin
            auto_waits <= 2'h0;
        end else if (in_tw & auto_wait_left) begin
            auto_waits <= auto_waits + WAIT_STEP;
        end
    end

    // Data lines are answered to our own strobes, so same-clock sampling
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata <= DATA_RESET;
        end else if (access_last & (is_read | is_int_ack)) begin
            rdata <= data_lines_in;
        end
    end

    // Refresh counter steps once per refresh slot
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            refresh_count <= REFRESH_RESET;
        end else if (in_t4 & is_fetch) begin
            refresh_count <= refresh_count + REFRESH_STEP;
        end
    end

    // Source served by the last acknowledge, latched at its start
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            served_source <= SOURCE_RESET;
        end else if (take & (req_kind_in == KIND_INT_ACK)) begin
            served_source <= unit_grant;
        end
    end

    // Grant register lags the float by one edge
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            grant_n <= 1'b1;
        end else begin
            grant_n <= ~(in_hold & bus_wanted);
        end
    end

    assign bus_grant_n_out = grant_n;

    ////////////////////////////////////////////////////////////////////////
    // Address and data pins
    wire [ADDR_W-1:0] refresh_addr = {refresh_high_in, refresh_addr_bit7_ctl_in,
                                      refresh_count};
    assign address_lines_out = in_refresh ? refresh_addr : addr;
    assign address_lines_oe_out = ~in_hold;
    assign data_lines_out = wdata;
    assign data_lines_oe_out = is_write & (in_access | in_t3) & ~in_hold;

    ////////////////////////////////////////////////////////////////////////
    // Strobes; decoded from one-hot flops, where each state change clears one bit and sets one
    wire memory_request_n_access = is_mem & in_access;
    wire memory_request_n_refresh = is_fetch & in_t4;
    wire io_request_n_io = is_io & (in_t2 | in_tw);
    wire io_request_n_ack = is_int_ack & in_tw;
    wire m1_low = (is_fetch | is_int_ack) & in_access;
    wire rd_low = is_read & in_access;
    wire wr_low = is_write & (in_t2 | in_tw);

    assign memory_request_n_out = ~(memory_request_n_access | memory_request_n_refresh);
    assign io_request_n_out = ~(io_request_n_io | io_request_n_ack);
    assign read_strobe_n_out = ~rd_low;
    assign write_strobe_n_out = ~wr_low;
    assign control_oe_out = ~in_hold;
    assign first_cycle_strobe_n_out = ~m1_low;
    assign first_cycle_strobe_oe_out = ~evaluator_float_sync;
    assign refresh_strobe_n_out = ~in_refresh;
    assign refresh_strobe_oe_out = ~evaluator_float_sync;
endmodule

`default_nettype wire

/* File: ceb_bus_cycles_chk.sv */
// Port-level assertions for the external bus cycle engine.
`default_nettype none

module ceb_bus_cycles_chk (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic evaluator_float_in,
    input wire logic refresh_addr_bit7_ctl_in,
    input wire logic [7:0] refresh_high_in,
    input wire logic [15:0] address_lines_out,
    input wire logic address_lines_oe_out,
    input wire logic [7:0] data_lines_out,
    input wire logic data_lines_oe_out,
    input wire logic first_cycle_strobe_n_out,
    input wire logic first_cycle_strobe_oe_out,
    input wire logic memory_request_n_out,
    input wire logic io_request_n_out,
    input wire logic read_strobe_n_out,
    input wire logic write_strobe_n_out,
    input wire logic control_oe_out,
    input wire logic refresh_strobe_n_out,
    input wire logic refresh_strobe_oe_out,
    input wire logic bus_grant_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    ////////////////////////////////////////////////////////////
    // Strobe pairings
    property p_fetch; !first_cycle_strobe_n_out && !memory_request_n_out
        |-> !read_strobe_n_out && io_request_n_out; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch strobes wrong");
    property p_inta; !io_request_n_out && !first_cycle_strobe_n_out && control_oe_out
        |-> memory_request_n_out && read_strobe_n_out; endproperty
    a_inta: assert property (p_inta) else $error("int ack strobes wrong");
    property p_refresh_strobe_n; !refresh_strobe_n_out && !memory_request_n_out
        |-> read_strobe_n_out && write_strobe_n_out; endproperty
    a_refresh_strobe_n: assert property (p_refresh_strobe_n) else $error("refresh strobes wrong");
    // Refresh address: bit 7 and upper byte follow their inputs live
    property p_raddr; !refresh_strobe_n_out && refresh_strobe_oe_out
        |-> address_lines_out[7] == refresh_addr_bit7_ctl_in
        && address_lines_out[15:8] == refresh_high_in; endproperty
    a_raddr: assert property (p_raddr) else $error("refresh address wrong");
    // Address and data must not move under a live strobe
    property p_maddr; (!memory_request_n_out && refresh_strobe_n_out) [*2]
        |-> address_lines_oe_out && $stable(address_lines_out); endproperty
    a_maddr: assert property (p_maddr) else $error("memory address moved");
    property p_ioaddr; !io_request_n_out
        |-> address_lines_oe_out && $stable(address_lines_out[7:0]); endproperty
    a_ioaddr: assert property (p_ioaddr) else $error("port address moved");
    property p_wdata; !write_strobe_n_out && control_oe_out
        |-> data_lines_oe_out && $stable(data_lines_out); endproperty
    a_wdata: assert property (p_wdata) else $error("write data not valid");
    // Hand-over: control, address and data floated while granted, control also the cycle before
    property p_grant; !bus_grant_n_out
        |-> !control_oe_out && !address_lines_oe_out && !data_lines_oe_out; endproperty
    a_grant: assert property (p_grant) else $error("bus driven while granted");
    property p_gfell; $fell(bus_grant_n_out) |-> !$past(control_oe_out); endproperty
    a_gfell: assert property (p_gfell) else $error("grant before float");
    // Two sync flops plus margin before the float must show
    property p_ev; evaluator_float_in [*4]
        |-> !first_cycle_strobe_oe_out && !refresh_strobe_oe_out; endproperty
    a_ev: assert property (p_ev) else $error("float input ignored");
    c_inta: cover property (!first_cycle_strobe_n_out && !io_request_n_out);
    c_grant: cover property ($fell(bus_grant_n_out));
    c_write: cover property (!write_strobe_n_out && control_oe_out);
endmodule

bind ceb_bus_cycles ceb_bus_cycles_chk u_ceb_bus_cycles_chk (.clk_in, .reset_n_in,
    .evaluator_float_in, .refresh_addr_bit7_ctl_in, .refresh_high_in, .address_lines_out,
    .address_lines_oe_out, .data_lines_out, .data_lines_oe_out, .first_cycle_strobe_n_out,
    .first_cycle_strobe_oe_out, .memory_request_n_out, .io_request_n_out, .read_strobe_n_out,
    .write_strobe_n_out, .control_oe_out, .refresh_strobe_n_out, .refresh_strobe_oe_out,
    .bus_grant_n_out);

`default_nettype wire

/* File: ceb_bus_cycles_tb_top.sv */
// Directed testbench for the external bus cycle engine.
`default_nettype none

module ceb_bus_cycles_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ceb_pkg::*;
    localparam logic [7:0] VEC = 8'h3C;
    logic clk_in = 0, reset_n_in = 0, req_valid_in = 0, req_ready_out, done_out;
    ceb_kind_type req_kind_in = KIND_FETCH;
    logic [15:0] req_addr_in = 16'h0000, address_lines_out;
    logic [7:0] req_wdata_in = 8'h00, refresh_high_in = 8'h00, rdata_out;
    logic [7:0] data_lines_in, data_lines_out;
    logic refresh_addr_bit7_ctl_in = 0, wait_n_in = 1, bus_request_n_in = 1;
    logic evaluator_float_in = 0, counter_timer_irq_in = 0, serial_irq_in = 0;
    logic priority_sel_in = 0, bus_grant_n_out, address_lines_oe_out, data_lines_oe_out;
    logic first_cycle_strobe_n_out, first_cycle_strobe_oe_out, memory_request_n_out;
    logic io_request_n_out, read_strobe_n_out, write_strobe_n_out, control_oe_out;
    logic refresh_strobe_n_out, refresh_strobe_oe_out, int_pending_out, m1_q = 1;
    logic [1:0] int_source_out;
    int num_errors = 0, samples_checked = 0, m1_falls = 0, n;

    ceb_bus_cycles u_ceb_bus_cycles (.clk_in, .reset_n_in, .req_valid_in, .req_ready_out,
        .req_kind_in, .req_addr_in, .req_wdata_in, .refresh_high_in, .refresh_addr_bit7_ctl_in,
        .done_out, .rdata_out, .wait_n_in, .bus_request_n_in, .bus_grant_n_out,
        .evaluator_float_in, .address_lines_out, .address_lines_oe_out, .data_lines_in,
        .data_lines_out, .data_lines_oe_out, .first_cycle_strobe_n_out,
        .first_cycle_strobe_oe_out, .memory_request_n_out, .io_request_n_out,
        .read_strobe_n_out, .write_strobe_n_out, .control_oe_out, .refresh_strobe_n_out,
        .refresh_strobe_oe_out, .counter_timer_irq_in, .serial_irq_in, .priority_sel_in,
        .int_pending_out, .int_source_out);
    ceb_bus_model #(.VECTOR(VEC)) u_ceb_bus_model (.clk_in, .addr_in(address_lines_out),
        .io_request_n_in(io_request_n_out), .first_cycle_strobe_n_in(first_cycle_strobe_n_out),
        .read_strobe_n_in(read_strobe_n_out), .write_strobe_n_in(write_strobe_n_out),
        .control_oe_in(control_oe_out), .wdata_in(data_lines_out), .data_out(data_lines_in));
    ////////////////////////////////////////////////////////////
    // Clock, and a count of first-cycle strobe pulses taken mid-cycle
    initial forever #25 clk_in = ~clk_in;
    always @(negedge clk_in) begin
        m1_q <= first_cycle_strobe_n_out;
        if (m1_q === 1'b1 && first_cycle_strobe_n_out === 1'b0) m1_falls <= m1_falls + 1;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One machine cycle; c counts cycles from the take edge to done
    task automatic bus(input ceb_kind_type k, input logic [15:0] a, input logic [7:0] d,
                       output int c);
        int i;
        @(posedge clk_in);
        req_valid_in <= 1;
        req_kind_in <= k;
        req_addr_in <= a;
        req_wdata_in <= d;
        for (i = 0; i < 60; i++) begin
            @(negedge clk_in);
            if (req_ready_out === 1'b1) break;
        end
        @(posedge clk_in);
        req_valid_in <= 0;
        for (c = 1; c < 60; c++) begin
            @(negedge clk_in);
            if (done_out === 1'b1) break;
        end
        if (c == 60 || i == 60) begin
            num_errors++;
            stop_test();
        end
    endtask
    task automatic t_mem();
        bus(KIND_MEM_WR, 16'h1234, 8'hA5, n);
        bus(KIND_MEM_RD, 16'h1234, 8'h00, n);
        chk("mem read data", 16'h00A5, rdata_out);
        chk("mem read length", 16'h0003, n);
        bus(KIND_IO_WR, 16'h005A, 8'hC3, n);
        bus(KIND_IO_RD, 16'h005A, 8'h00, n);
        chk("io read data", 16'h00C3, rdata_out);
        $display("test mem and io done");
    endtask
    task automatic t_fetch();
        int f;
        @(posedge clk_in);
        refresh_high_in <= 8'h9E;
        refresh_addr_bit7_ctl_in <= 1;
        f = m1_falls;
        bus(KIND_FETCH, 16'h1234, 8'h00, n);
        chk("fetch data", 16'h00A5, rdata_out);
        chk("refresh address", 16'h9E80, address_lines_out);
        chk("refresh strobes", 16'h0000, {refresh_strobe_n_out, memory_request_n_out});
        bus(KIND_FETCH, 16'h1235, 8'h00, n);
        chk("fetch length", 16'h0004, n);
        chk("next refresh address", 16'h9E81, address_lines_out);
        chk("opcode strobe pulses", 16'h0002, m1_falls - f);
        $display("test fetch done");
    endtask
    task automatic t_inta();
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_in);
            priority_sel_in <= s[0];
            counter_timer_irq_in <= 1;
            serial_irq_in <= 1;
            bus(KIND_INT_ACK, 16'h0000, 8'h00, n);
            chk("vector", {8'h00, VEC}, rdata_out);
            chk("ack length", 16'h0006, n);
            chk("winner", s ? 16'h0002 : 16'h0001, int_source_out);
            chk("pending", 16'h0001, int_pending_out);
        end
        @(posedge clk_in);
        counter_timer_irq_in <= 0;
        serial_irq_in <= 0;
        $display("test int ack done");
    endtask
    task automatic t_wait();
        @(posedge clk_in);
        wait_n_in <= 0;
        fork
            begin
                repeat (8) @(posedge clk_in);
                wait_n_in <= 1;
            end
        join_none
        bus(KIND_MEM_RD, 16'h1234, 8'h00, n);
        chk("stretched", 16'h0001, n > 6);
        chk("stretched data", 16'h00A5, rdata_out);
        $display("test wait done");
    endtask
    task automatic t_hold();
        int i;
        fork
            begin
                repeat (2) @(posedge clk_in);
                bus_request_n_in <= 0;
            end
        join_none
        bus(KIND_MEM_RD, 16'h1234, 8'h00, n);
        chk("cycle finished first", 16'h0003, n);
        for (i = 0; i < 20 && bus_grant_n_out !== 1'b0; i++) @(negedge clk_in);
        chk("grant", 16'h0000, bus_grant_n_out);
        chk("floated", 16'h0000, {control_oe_out, address_lines_oe_out});
        chk("refused", 16'h0000, req_ready_out);
        @(posedge clk_in);
        bus_request_n_in <= 1;
        repeat (6) @(negedge clk_in);
        chk("driving again", 16'h0003, {bus_grant_n_out, address_lines_oe_out});
        $display("test hold done");
    endtask
    task automatic t_ev();
        @(posedge clk_in);
        evaluator_float_in <= 1;
        repeat (5) @(negedge clk_in);
        chk("float", 16'h0000, {first_cycle_strobe_oe_out, refresh_strobe_oe_out});
        @(posedge clk_in);
        evaluator_float_in <= 0;
        repeat (5) @(negedge clk_in);
        chk("unfloat", 16'h0003, {first_cycle_strobe_oe_out, refresh_strobe_oe_out});
        $display("test float done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1;
        repeat (3) @(posedge clk_in);
        t_mem();
        t_fetch();
        t_inta();
        t_wait();
        t_hold();
        t_ev();
        stop_test();
    end
endmodule

`default_nettype wire

/* File: ceb_bus_model.sv */
// Memory and port responder standing on the far side of the bus.
`default_nettype none

module ceb_bus_model #(
    parameter logic [7:0] VECTOR = 8'h3C
) (
    input wire logic clk_in,
    input wire logic [15:0] addr_in,
    input wire logic io_request_n_in,
    input wire logic first_cycle_strobe_n_in,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic control_oe_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h55;
    wire drive_vec = !io_request_n_in && !first_cycle_strobe_n_in;
    wire drive_rd = !read_strobe_n_in && control_oe_in;
    ////////////////////////////////////////////////////////////
    // Released bus shows the inverse of the last byte, never that byte itself
    assign data_out = drive_vec ? VECTOR : drive_rd ? mem[addr_in[7:0]] : ~last;
    // Store on the write strobe, remember last byte put out
    always @(posedge clk_in) begin
        if (drive_vec || drive_rd) begin
            last <= data_out;
        end
        if (!write_strobe_n_in && control_oe_in) begin
            mem[addr_in[7:0]] <= wdata_in;
        end
    end
endmodule

`default_nettype wire

/* File: ceb_int_priority.sv */
// Selectable-order priority pick among built-in interrupt sources.
`default_nettype none

module ceb_int_priority #(
    parameter int NUM = 2
) (
    input wire logic [NUM-1:0] irq_in,
    input wire logic reverse_order_in,
    output logic [NUM-1:0] grant_out,
    output logic any_out
);
    logic [NUM-1:0] ordered;
    logic [NUM:0] blocked;
    logic [NUM-1:0] pick;

    // Elaboration refuses a single unit; an order flip needs two
    if (NUM < 2) begin : g_bad_num
        $error("ceb_int_priority: NUM must be at least 2");
    end

    assign blocked[0] = 1'b0;
    assign any_out = |irq_in;

    // Order is flipped by software, so either unit can win a tie
    genvar i;
    generate
        for (i = 0; i < NUM; i++) begin : g_chan
            assign ordered[i] = reverse_order_in ? irq_in[NUM-1-i] : irq_in[i];
            assign pick[i] = ordered[i] & ~blocked[i];
            assign blocked[i+1] = blocked[i] | ordered[i];
            assign grant_out[i] = reverse_order_in ? pick[NUM-1-i] : pick[i];
        end
    endgenerate
endmodule

`default_nettype wire

/* File: ceb_pkg.sv */
// Shared constants and types for the external bus cycle engine.
`default_nettype none

package ceb_pkg;

    // Bus widths and interrupt unit count
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int REFRESH_W = 7;
    localparam int IO_ADDR_W = 8;
    localparam int NUM_IRQ_UNITS = 2;

    // Values after reset
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [REFRESH_W-1:0] REFRESH_RESET = 7'h00;
    localparam logic [1:0] SOURCE_RESET = 2'h0;

    // Cycle counts
    localparam logic [1:0] INTA_AUTO_WAITS = 2'h2;
    localparam logic [REFRESH_W-1:0] REFRESH_STEP = 7'h01;
    localparam logic [1:0] WAIT_STEP = 2'h1;

    // Field positions
    localparam int REFRESH_BIT7_POS = 7;
    localparam int TIMER_UNIT_IDX = 0;
    localparam int SERIAL_UNIT_IDX = 1;

    // Kinds of bus cycle the core may ask for
    typedef enum logic [2:0] {
        KIND_FETCH = 3'h0,
        KIND_MEM_RD = 3'h1,
        KIND_MEM_WR = 3'h2,
        KIND_IO_RD = 3'h3,
        KIND_IO_WR = 3'h4,
        KIND_INT_ACK = 3'h5
    } ceb_kind_type;

    // T-state sequencer, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_T1 = 7'h02,
        ST_T2 = 7'h04,
        ST_TW = 7'h08,
        ST_T3 = 7'h10,
        ST_T4 = 7'h20,
        ST_HOLD = 7'h40
    } ceb_state_type;

endpackage

`default_nettype wire

/* File: ceb_sync.sv */
// Two-flop synchroniser for asynchronous control pins.
`default_nettype none

module ceb_sync #(
    parameter int WIDTH = 1,
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // Elaboration refuses an empty synchroniser
    if (WIDTH < 1) begin : g_bad_width
        $error("ceb_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage_one <= {WIDTH{RESET_LEVEL}};
            sync_out <= {WIDTH{RESET_LEVEL}};
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule

`default_nettype wire
